// ---- smd_module_end.sv ----
// stepper module end: takes images and decodes mode, command, parameters
`timescale 1ns/1ps
`include "smd_image_defines.svh"
module smd_module_end
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    // link
    smd_image_if.module_end        link,
    // motion core feedback
    input  wire logic              i_motion_busy,
    input  wire logic              i_encoder_mode,
    // decoded instant command
    output logic                   o_cmd_valid,
    output smd_image_pkg::cmd_t    o_cmd,
    output logic                   o_dir_fwd,
    output logic                   o_input_rise,
    output logic                   o_hard_stop,
    output logic      [1:0]        o_goto_target,
    output logic      [31:0]       o_value,
    // home, mark and high impedance
    output logic                   o_pos_clear,
    output logic                   o_enc_clear,
    output logic      [31:0]       o_mark_pos,
    output logic                   o_hiz,
    // position table operation
    output logic                   o_tab_valid,
    output logic      [3:0]        o_tab_op,
    output logic      [7:0]        o_tab_index
);
    import smd_image_pkg::*;

    typedef enum logic {
        M_IDLE   = 1'b0,
        M_DECODE = 1'b1
    } module_state_t;

    typedef struct packed {
        module_state_t state;
        image_t        img;
        logic          cmd_valid;
        cmd_t          cmd;
        logic          dir_fwd;
        logic          input_rise;
        logic          hard_stop;
        logic [1:0]    target;
        logic [31:0]   value;
        logic          pos_clear;
        logic          enc_clear;
        logic [31:0]   mark;
        logic          hiz;
        logic          tab_valid;
        logic [3:0]    tab_op;
        logic [7:0]    tab_index;
        status_t       code;
        logic          done;
    } module_t;

    module_t st;
    module_t next_st;

    // image fields, taken from fixed byte places
    logic [`MODE_BITS-1:0] mode;
    logic [3:0]            code_raw;
    logic [7:0]            para1;
    logic [7:0]            para2;
    logic [31:0]           value;
    logic                  one_mode;

    always_comb
    begin
        mode     = st.img[`IMG_MODE_BYTE*8 +: `MODE_BITS];
        code_raw = st.img[`IMG_CMD_BYTE*8 +: 4];
        para1    = st.img[`IMG_PARA1_BYTE*8 +: 8];
        para2    = st.img[`IMG_PARA2_BYTE*8 +: 8];
        // bytes 5..8, byte 5 least significant
        value    = st.img[`IMG_VALUE_BYTE*8 +: 32];
        // act only on a single mode bit
        one_mode = $onehot(mode);
    end

    // decode and command issue
    always_comb
    begin
        next_st = st;
        next_st.cmd_valid = 1'b0;
        next_st.pos_clear = 1'b0;
        next_st.enc_clear = 1'b0;
        next_st.tab_valid = 1'b0;
        next_st.done      = 1'b0;
        unique case (st.state)
            M_IDLE:
                if (link.img_valid)
                begin
                    // whole ten-byte image taken in one beat
                    next_st.img   = link.img;
                    next_st.state = M_DECODE;
                end
            M_DECODE:
            begin
                next_st.state = M_IDLE;
                next_st.done  = 1'b1;
                next_st.code  = `STAT_OK;
                // fields always follow the image for the motion core
                next_st.cmd        = cmd_t'(code_raw);
                next_st.dir_fwd    = para1[0];
                next_st.input_rise = para1[0];
                next_st.hard_stop  = para2[0];
                next_st.target     = para2[1:0];
                next_st.value      = value;
                if (!one_mode)
                    next_st.code = `STAT_ERROR;
                else if (mode[`MODE_INSTANT])
                begin
                    // instant mode runs at once; index left alone
                    next_st.cmd_valid = 1'b1;
                    unique case (code_raw)
                        CMD_NOP:
                            next_st.cmd_valid = 1'b0;
                        CMD_SET_HOME:
                        begin
                            next_st.pos_clear = 1'b1;
                            next_st.enc_clear = i_encoder_mode;
                        end
                        CMD_SET_MARK:
                            next_st.mark = value;
                        CMD_GOTO:
                            if (i_motion_busy)
                            begin
                                // refused until busy shows completion
                                next_st.cmd_valid = 1'b0;
                                next_st.code      = `STAT_BUSY;
                            end
                            else if (para2 > {6'h00, `TARGET_ABS})
                            begin
                                next_st.cmd_valid = 1'b0;
                                next_st.code      = `STAT_ERROR;
                            end
                        travel_in_direction_cmd, CMD_MOVE, CMD_RUN,
                        CMD_CLEAR:
                            next_st.cmd_valid = 1'b1;
                        CMD_STOP:
                            next_st.hiz = 1'b0;
                        CMD_HIGH_Z:
                            next_st.hiz = 1'b1;
                        default:
                        begin
                            // table-only codes and unused codes
                            next_st.cmd_valid = 1'b0;
                            next_st.code      = `STAT_ERROR;
                        end
                    endcase
                end
                else
                begin
                    // no-op in a table acts as wait, count in value
                    if (code_raw > CMD_HIGH_Z)
                        // refused entry leaves op and index as they were
                        next_st.code = `STAT_ERROR;
                    else
                    begin
                        // position table op: entry fields go with it
                        next_st.tab_valid = 1'b1;
                        next_st.tab_op    = mode[`MODE_BITS-1:`MODE_TAB_WRITE];
                        next_st.tab_index =
                            st.img[`IMG_INDEX_BYTE*8 +: 8];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st       <= '0;
            st.state <= M_IDLE;
            st.mark  <= `RST_MARK;
            st.hiz   <= `RST_HIZ;   // driver starts in high impedance
        end
        else
            st <= next_st;
    end

    // ready only while idle, so one image at a time is decoded
    assign link.img_ready = (st.state == M_IDLE);
    assign link.st_busy   = i_motion_busy;
    assign link.st_hiz    = st.hiz;
    assign link.st_code   = st.code;
    assign link.st_done   = st.done;

    // registered user outputs
    assign o_cmd_valid   = st.cmd_valid;
    assign o_cmd         = st.cmd;
    assign o_dir_fwd     = st.dir_fwd;
    assign o_input_rise  = st.input_rise;
    assign o_hard_stop   = st.hard_stop;
    assign o_goto_target = st.target;
    assign o_value       = st.value;
    assign o_pos_clear   = st.pos_clear;
    assign o_enc_clear   = st.enc_clear;
    assign o_mark_pos    = st.mark;
    assign o_hiz         = st.hiz;
    assign o_tab_valid   = st.tab_valid;
    assign o_tab_op      = st.tab_op;
    assign o_tab_index   = st.tab_index;
endmodule

// ---- smd_image_defines.svh ----
// constants for the stepper output image link and the controller registers
//
// Behaviour
// - output image is exactly ten bytes
// - byte 3 bit 0 picks direction, 1 forward
// - input query byte 3: 1 off-to-on edge
// - stop byte 4 bit 0: 1 hard stop
// - goto byte 4: home, mark, absolute target
// - bytes 5-8 carry value, low byte first
// - only one output mode acts at once
// - instant mode and position table mode exist
// - adapter sends stop before any other command
// - table index ignored in instant mode
// - code 0 no-op, table wait count
// - code 1 clears position, encoder too in encoder mode
// - code 2 loads value into mark register
// - goto ignored while motion still busy
`ifndef SMD_IMAGE_DEFINES_SVH
`define SMD_IMAGE_DEFINES_SVH

// image layout
`define IMG_BYTES       10
`define IMG_BITS        80
`define IMG_MODE_BYTE   0
`define IMG_INDEX_BYTE  1
`define IMG_CMD_BYTE    2
`define IMG_PARA1_BYTE  3
`define IMG_PARA2_BYTE  4
`define IMG_VALUE_BYTE  5
`define MODE_INSTANT    0
`define MODE_TAB_WRITE  1
`define MODE_BITS       5

// goto target selector values
`define TARGET_HOME     2'h0
`define TARGET_MARK     2'h1
`define TARGET_ABS      2'h2

// command status codes reported back to the adapter
`define STAT_OK         2'h0
`define STAT_ERROR      2'h1
`define STAT_BUSY       2'h2

// reset values
`define RST_MARK        32'h0000_0000
`define RST_HIZ         1'b1

// controller register offsets, control and status bit positions
`define REG_IMG_LAST    4'h9
`define REG_CTRL        4'hA
`define REG_STATUS      4'hB
`define CTRL_SEND_BIT   0
`define STS_PEND_BIT    0
`define STS_BUSY_BIT    1
`define STS_HIZ_BIT     2
`define STS_STOP_BIT    3
`define STS_CODE_LSB    4

`endif

// ---- smd_image_pkg.sv ----
// types shared by both ends of the stepper output image link
`include "smd_image_defines.svh"
package smd_image_pkg;

    // command codes in the low nibble of the command byte
    typedef enum logic [3:0] {
        CMD_NOP          = 4'h0,
        CMD_SET_HOME     = 4'h1,
        CMD_SET_MARK     = 4'h2,
        CMD_GOTO         = 4'h3,
        travel_in_direction_cmd = 4'h4,
        CMD_MOVE         = 4'h5,
        CMD_RUN          = 4'h6,
        CMD_INPUT_QUERY  = 4'h7,
        CMD_STOP         = 4'h8,
        CMD_GOTO_ENTRY   = 4'h9,
        CMD_CLEAR        = 4'hA,
        CMD_HIGH_Z       = 4'hB
    } cmd_t;

    typedef logic [`IMG_BITS-1:0] image_t;
    typedef logic [1:0]           status_t;

endpackage

// ---- smd_image_if.sv ----
// link between the network adapter end and the stepper module end
`timescale 1ns/1ps
interface smd_image_if;
    import smd_image_pkg::*;

    logic    img_valid;   // adapter offers a full image
    logic    img_ready;   // module can take an image
    image_t  img;         // ten image bytes, byte 0 in bits 7:0
    logic    st_busy;     // motion in progress
    logic    st_hiz;      // driver in high impedance
    status_t st_code;     // result of last command
    logic    st_done;     // one-cycle pulse, image decoded

    modport adapter
    (
        output img_valid, img,
        input  img_ready, st_busy, st_hiz, st_code, st_done
    );
    modport module_end
    (
        input  img_valid, img,
        output img_ready, st_busy, st_hiz, st_code, st_done
    );
endinterface

// ---- smd_adapter_end.sv ----
// adapter end: builds the image from registers and sends it
`timescale 1ns/1ps
`include "smd_image_defines.svh"
module smd_adapter_end
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    // register port
    input  wire logic [3:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    // link
    smd_image_if.adapter           link
);
    import smd_image_pkg::*;

    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_STOP = 2'b01,
        A_USER = 2'b11
    } adapter_state_t;

    typedef struct packed {
        adapter_state_t state;
        image_t         img;
        logic           pend;
        logic           stop_done;
        logic [7:0]     rdata;
    } adapter_t;

    adapter_t st;
    adapter_t next_st;
    image_t   stop_img;

    // soft stop in instant mode, all else zero
    always_comb
    begin
        stop_img = '0;
        stop_img[`IMG_MODE_BYTE*8 + `MODE_INSTANT] = 1'b1;
        stop_img[`IMG_CMD_BYTE*8 +: 4] = CMD_STOP;
    end

    // register access and send sequencing
    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (i_wr && i_addr <= `REG_IMG_LAST)
            next_st.img[i_addr*8 +: 8] = i_wdata;
        if (i_rd)
        begin
            if (i_addr <= `REG_IMG_LAST)
                next_st.rdata = st.img[i_addr*8 +: 8];
            else if (i_addr == `REG_STATUS)
            begin
                next_st.rdata[`STS_PEND_BIT] = st.pend;
                next_st.rdata[`STS_BUSY_BIT] = link.st_busy;
                next_st.rdata[`STS_HIZ_BIT]  = link.st_hiz;
                next_st.rdata[`STS_STOP_BIT] = st.stop_done;
                next_st.rdata[`STS_CODE_LSB +: 2] = link.st_code;
            end
        end
        unique case (st.state)
            A_IDLE:
                if (st.pend)
                    // driver wakes in high impedance, so stop goes first
                    next_st.state = st.stop_done ? A_USER : A_STOP;
            A_STOP:
                if (link.img_ready)
                begin
                    next_st.stop_done = 1'b1;
                    next_st.state = A_USER;
                end
            A_USER:
                if (link.img_ready)
                begin
                    next_st.pend  = 1'b0;
                    next_st.state = A_IDLE;
                end
        endcase
        // a new send request wins over the clear of a finishing one
        if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_SEND_BIT])
            next_st.pend = 1'b1;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            st <= '{A_IDLE, '0, 1'b0, 1'b0, 8'h00};
        else
            st <= next_st;
    end

    // image offered from the image registers, or the stop image while in A_STOP
    assign link.img_valid = (st.state == A_STOP) || (st.state == A_USER);
    assign link.img       = (st.state == A_STOP) ? stop_img : st.img;
    assign o_rdata        = st.rdata;
endmodule

// ---- smd_image_asserts.sv ----
// concurrent checks on the stepper output image link
`timescale 1ns/1ps
module smd_image_asserts
(
    // clock and reset
    input wire logic                   i_sys_clk,
    input wire logic                   i_reset,
    // link signals
    input wire logic                   img_valid,
    input wire logic                   img_ready,
    input wire smd_image_pkg::image_t  img,
    input wire logic                   st_busy,
    input wire logic                   st_hiz,
    input wire smd_image_pkg::status_t st_code,
    input wire logic                   st_done
);
    import smd_image_pkg::*;
    logic       take;
    logic       inst;
    logic       seen;
    logic [3:0] code;

    // handshake and instant-mode decode helpers
    assign take = img_valid && img_ready;
    assign inst = take && img[7:0] == 8'h01;
    assign code = img[19:16];

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    // first take since reset; the adapter must open with a stop
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            seen <= 1'b0;
        else if (take)
            seen <= 1'b1;
    end

    chk_done_delay: assert property (take |-> ##2 st_done)
        else $error("done pulse late after image take");
    chk_done_cause: assert property (st_done |-> $past(take, 2))
        else $error("done pulse without image take");
    chk_ready_gap: assert property (take |=> !img_ready)
        else $error("ready not dropped after take");
    chk_valid_hold: assert property
        (img_valid && !img_ready |=> img_valid && $stable(img))
        else $error("image changed while waiting");
    chk_first_stop: assert property (take && !seen |->
        img[7:0] == 8'h01 && code == 4'h8 && !img[32])
        else $error("first image is not a soft stop");
    chk_mode_onehot: assert property
        (take && !$onehot(img[4:0]) |-> ##2 st_code == 2'h1)
        else $error("bad mode byte not refused");
    chk_bad_code: assert property (inst && (code == 4'h7 ||
        code == 4'h9 || code > 4'hB) |-> ##2 st_code == 2'h1)
        else $error("illegal instant code not refused");
    chk_goto_busy: assert property
        (inst && code == 4'h3 && st_busy |-> ##2 st_code == 2'h2)
        else $error("goto while busy not reported busy");
    chk_goto_target: assert property (inst && code == 4'h3 &&
        !st_busy && img[39:32] > 8'h02 |-> ##2 st_code == 2'h1)
        else $error("bad goto target not refused");
    chk_stop_hiz: assert property
        (inst && code == 4'h8 |-> ##2 !st_hiz && st_code == 2'h0)
        else $error("stop did not release high impedance");
    chk_hiz_set: assert property (inst && code == 4'hB |-> ##2 st_hiz)
        else $error("high impedance command ignored");

    // main scenarios
    cover property (inst && code == 4'h3 && st_busy);
    cover property (take && !seen);
    cover property (take && img[7:0] == 8'h10);
endmodule

// ---- stepper_output_command_decoder_tb.sv ----
// self-checking bench for both ends of the stepper output image link
`timescale 1ns/1ps
module stepper_output_command_decoder_tb;
    import smd_image_pkg::*;
    typedef struct packed
    {
        logic [7:0]  mode;
        logic [7:0]  idx;
        logic [3:0]  cmd;
        logic [3:0]  p1;
        logic [3:0]  p2;
        logic [31:0] val;
        logic        busy;
        logic        enc;
        logic        cv;
        logic        tv;
        logic [3:0]  code;
    } row_t;

    logic        i_sys_clk;
    logic        i_reset;
    logic [3:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  o_rdata;
    logic        i_motion_busy;
    logic        i_encoder_mode;
    logic        o_cmd_valid;
    cmd_t        o_cmd;
    logic        o_dir_fwd;
    logic        o_input_rise;
    logic        o_hard_stop;
    logic [1:0]  o_goto_target;
    logic [31:0] o_value;
    logic        o_pos_clear;
    logic        o_enc_clear;
    logic [31:0] o_mark_pos;
    logic        o_hiz;
    logic        o_tab_valid;
    logic [3:0]  o_tab_op;
    logic [7:0]  o_tab_index;
    int          n_errors;
    int          n_checks;
    int          n_done;
    logic [3:0]  pl;
    logic        first;
    logic [7:0]  d;
    logic [31:0] mark;
    logic        hiz;
    logic [7:0]  idx;
    row_t        r;
    // mode idx | cmd p1 p2 | value | busy enc cv tv | status
    row_t rows [27] = '{
        68'h0100_000_00000000_00, 68'h0100_100_00000000_60,
        68'h0100_100_00000000_20, 68'h0100_200_000000C8_20,
        68'h0100_300_00000000_20, 68'h0100_301_00000000_20,
        68'h0100_302_0000C800_20, 68'h0100_303_00000000_01,
        68'h0100_302_00000000_82, 68'h015A_400_00000010_20,
        68'h0100_510_12345678_20, 68'h0100_610_00000100_20,
        68'h0100_700_00000000_01, 68'h0100_900_00000000_01,
        68'h0100_F00_00000000_01, 68'h0100_B00_00000000_20,
        68'h0100_801_00000000_20, 68'h0100_A00_00000000_20,
        68'h0100_800_00000000_20, 68'h0000_100_00000000_01,
        68'h0300_100_00000000_01, 68'h0211_710_00000000_10,
        68'h0422_900_00000005_10, 68'h0833_700_00000000_10,
        68'h1044_000_00000064_10, 68'h0255_C00_00000000_01,
        68'h0177_000_00000000_00};

    smd_image_if link ();
    smd_adapter_end i_smd_adapter_end (.i_sys_clk, .i_reset, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .link(link));
    smd_module_end i_smd_module_end (.i_sys_clk, .i_reset, .link(link),
        .i_motion_busy, .i_encoder_mode, .o_cmd_valid, .o_cmd, .o_dir_fwd,
        .o_input_rise, .o_hard_stop, .o_goto_target, .o_value, .o_pos_clear,
        .o_enc_clear, .o_mark_pos, .o_hiz, .o_tab_valid, .o_tab_op,
        .o_tab_index);
    smd_image_asserts i_smd_image_asserts (.i_sys_clk, .i_reset,
        .img_valid(link.img_valid), .img_ready(link.img_ready),
        .img(link.img), .st_busy(link.st_busy), .st_hiz(link.st_hiz),
        .st_code(link.st_code), .st_done(link.st_done));

    // 200 MHz clock
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    // pulses only stand one cycle, so latch them at the done pulse;
    // sampled mid-cycle, clear of the edge that launches them
    always @(negedge i_sys_clk)
    begin
        if (link.st_done === 1'b1)
        begin
            pl = {o_cmd_valid, o_tab_valid, o_pos_clear, o_enc_clear};
            n_done++;
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= v;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    // the first send after reset also carries the automatic stop
    task automatic send(input row_t s);
        int want;
        want = n_done + (first ? 2 : 1);
        @(posedge i_sys_clk);
        i_motion_busy <= s.busy;
        i_encoder_mode <= s.enc;
        wr(4'h0, s.mode);
        wr(4'h1, s.idx);
        wr(4'h2, {4'h0, s.cmd});
        wr(4'h3, {4'h0, s.p1});
        wr(4'h4, {4'h0, s.p2});
        for (int b = 0; b < 4; b++)
            wr(4'(5 + b), s.val[8*b +: 8]);
        wr(4'h9, 8'h00);
        wr(4'hA, 8'h01);
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        for (int k = 0; k < 60 && n_done < want; k++)
            @(posedge i_sys_clk) #1;
        chk(48'(n_done >= want), 48'h1);
        first = 1'b0;
    endtask

    task automatic reset_dut();
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        i_motion_busy <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        #1 chk({o_hiz, link.st_hiz, link.img_ready, link.img_valid,
                o_cmd_valid, o_tab_valid, o_mark_pos}, 48'h38_0000_0000);
        rd(4'hB, d);
        chk(d, 8'h04);
        first = 1'b1;
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog well beyond the expected run of a few hundred cycles
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        {i_reset, i_addr, i_wdata, i_wr, i_rd} = '0;
        {i_motion_busy, i_encoder_mode} = 2'h0;
        {n_errors, n_checks, n_done, mark, idx} = '0;
        i_reset = 1'b1;
        reset_dut();
        hiz = 1'b0; // the opening stop releases high impedance
        foreach (rows[i])
        begin
            r = rows[i];
            send(r);
            if (r.cv && r.cmd == 4'h2) mark = r.val;
            if (r.cv && r.cmd == 4'hB) hiz = 1'b1;
            if (r.cv && r.cmd == 4'h8) hiz = 1'b0;
            if (r.tv) idx = r.idx;
            chk(link.st_code, r.code);
            chk(pl, {r.cv, r.tv, r.cv && r.cmd == 4'h1,
                r.cv && r.cmd == 4'h1 && r.enc});
            chk(o_mark_pos, mark);
            chk({o_hiz, link.st_hiz, o_tab_index}, {hiz, hiz, idx});
            if (r.cv) chk({o_cmd, o_value}, {r.cmd, r.val});
            if (r.cv && r.cmd inside {4'h4, 4'h5, 4'h6})
                chk(o_dir_fwd, r.p1[0]);
            if (r.cv && r.cmd == 4'h8) chk(o_hard_stop, r.p2[0]);
            if (r.cv && r.cmd == 4'h3) chk(o_goto_target, r.p2[1:0]);
            if (r.tv) chk(o_tab_op, r.mode[4:1]);
            if (r.tv && r.cmd == 4'h7) chk(o_input_rise, r.p1[0]);
        end
        // status, readback and refused places, back to back
        @(posedge i_sys_clk);
        i_motion_busy <= 1'b1;
        rd(4'hB, d);
        chk(d, 8'h0A);
        rd(4'h1, d);
        chk(d, 8'h77);
        wr(4'hC, 8'hFF);
        rd(4'hC, d);
        chk(d, 8'h00);
        rd(4'hA, d);
        chk(d, 8'h00);
        // reset mid-run, then the stop must be sent again
        reset_dut();
        send(rows[1]);
        chk({pl, o_hiz}, 5'h16);
        end_of_test();
    end
endmodule
